// File: rtl/temo_pkg.sv
// package for the timer external match output stage
package temo_pkg;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  // register byte addresses
  localparam logic [ADDR_W-1:0] MATCH_OUTPUT_CONTROL_ADDR = 32'h4001403c;
  // field positions
  localparam int LEVEL_LSB = 0;
  localparam int ACTION_LSB = 4;
  localparam int ACTION_W = 2;
  localparam int USED_BITS = 12;
  // reset values
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [7:0] ACTION_RESET = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // match action encodings
  typedef enum logic [1:0] {
    TEMO_ACT_NONE = 2'b00,
    TEMO_ACT_CLEAR = 2'b01,
    TEMO_ACT_SET = 2'b10,
    TEMO_ACT_TOGGLE = 2'b11
  } temo_action_t;

  // write state of the bus slave
  typedef enum logic [1:0] {
    TEMO_WR_IDLE = 2'b00,
    TEMO_WR_RESP = 2'b01
  } temo_wr_state_t;

  // write request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } temo_wreq_t;
endpackage : temo_pkg

// File: rtl/temo_match_out.sv
// timer external match output stage with axi4-lite register slave
`timescale 1ns/1ps
module temo_match_out
  import temo_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [31:0] TIMER_COUNT_VALUE,
  input wire logic [31:0] COMPARE_VALUE_0,
  input wire logic [31:0] COMPARE_VALUE_1,
  input wire logic [31:0] COMPARE_VALUE_2,
  input wire logic [31:0] COMPARE_VALUE_3,
  input wire logic [3:0] MATCH_EVENT_EN,
  input wire logic [3:0] PWM_CHANNEL_ENABLE,
  input wire logic [3:0] PWM_LEVEL,
  input wire logic [3:0] PIN_FUNCTION_SELECT,
  output logic [3:0] MATCH_PIN_OUT,
  output logic [3:0] MATCH_PIN_OE,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // the logic is written for exactly four channels
  if (CH != NUM_CH) begin : g_bad_ch
    $error("temo_match_out supports exactly four channels");
  end

  // applies one action code to a level
  function automatic logic apply_action(input logic [1:0] act,
                                        input logic lvl);
    case (act)
      TEMO_ACT_NONE: apply_action = lvl;
      TEMO_ACT_CLEAR: apply_action = 1'b0;
      TEMO_ACT_SET: apply_action = 1'b1;
      TEMO_ACT_TOGGLE: apply_action = ~lvl;
      default: apply_action = lvl;
    endcase
  endfunction : apply_action

  // address decode shared by read and write side
  function automatic logic hit_reg(input logic [31:0] a);
    hit_reg = (a[31:2] == MATCH_OUTPUT_CONTROL_ADDR[31:2]);
  endfunction : hit_reg

  logic [3:0] level_q;
  logic [3:0] level_d;
  logic [7:0] action_q;
  logic [3:0] match_eq;
  logic [31:0] cmp [4];
  logic [3:0] level_next;

  // latched write halves; address and data may come in either order
  temo_wreq_t wreq_q;
  logic aw_have_q;
  logic w_have_q;
  temo_wr_state_t wr_state_q;
  logic wr_fire;
  logic wr_hit;

  assign cmp[0] = COMPARE_VALUE_0;
  assign cmp[1] = COMPARE_VALUE_1;
  assign cmp[2] = COMPARE_VALUE_2;
  assign cmp[3] = COMPARE_VALUE_3;

  // per-channel equality and next level
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [1:0] act;
    logic lvl_match;
    assign match_eq[i] = MATCH_EVENT_EN[i] &&
                         (TIMER_COUNT_VALUE == cmp[i]);
    assign act = action_q[ACTION_LSB - 4 + 2*i +: ACTION_W];
    assign lvl_match = match_eq[i] ? apply_action(act, level_q[i])
                                   : level_q[i];
    // pwm overrides the action behaviour for this channel
    assign level_d[i] = PWM_CHANNEL_ENABLE[i] ? PWM_LEVEL[i]
                                              : lvl_match;
  end
  // full next level with any software write merged in; the pins use it
  // too, so a pin never lags its level by a cycle after a write
  always_comb begin
    level_next = level_d;
    if (wr_fire && wr_hit && wreq_q.strb[0]) begin
      for (int i = 0; i < 4; i++) begin
        // a match or pwm in the write cycle beats the written value
        if (!match_eq[i] && !PWM_CHANNEL_ENABLE[i]) begin
          level_next[i] = wreq_q.data[LEVEL_LSB + i];
        end
      end
    end
  end

  assign wr_fire = aw_have_q && w_have_q && (wr_state_q == TEMO_WR_IDLE);
  assign wr_hit = hit_reg(wreq_q.addr);

  // level bits; a counter event is never lost to a software write
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      level_q <= LEVEL_RESET;
    end else begin
      level_q <= level_next;
    end
  end

  // action fields, loaded straight from the bus
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      action_q <= ACTION_RESET;
    end else if (wr_fire && wr_hit) begin
      if (wreq_q.strb[0]) begin
        action_q[3:0] <= wreq_q.data[7:4];
      end
      if (wreq_q.strb[1]) begin
        action_q[7:4] <= wreq_q.data[11:8];
      end
    end
  end

  // pins driven from registers; enable follows the pin function
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MATCH_PIN_OUT <= 4'h0;
      MATCH_PIN_OE <= 4'h0;
    end else begin
      MATCH_PIN_OUT <= level_next & PIN_FUNCTION_SELECT;
      MATCH_PIN_OE <= PIN_FUNCTION_SELECT;
    end
  end

  // write address and data capture in one process, since both halves
  // land in the same carrier and it must have a single driver
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wreq_q <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        wreq_q.addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wreq_q.data <= S_AXI_WDATA;
        wreq_q.strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = !aw_have_q && (wr_state_q == TEMO_WR_IDLE);
  assign S_AXI_WREADY = !w_have_q && (wr_state_q == TEMO_WR_IDLE);

  // write response; unmapped addresses answer slverr
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_state_q <= TEMO_WR_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        TEMO_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= TEMO_WR_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        TEMO_WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state_q <= TEMO_WR_IDLE;
            S_AXI_BVALID <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= TEMO_WR_IDLE;
          S_AXI_BVALID <= 1'b0;
        end
      endcase
    end
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // read path; upper bits read zero, software must not rely on them
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      if (hit_reg(S_AXI_ARADDR)) begin
        S_AXI_RDATA <= {20'h0, action_q, level_q};
        S_AXI_RRESP <= RESP_OKAY;
      end else begin
        S_AXI_RDATA <= 32'h0;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // assertions
  a_clear_action: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    match_eq[0] && !PWM_CHANNEL_ENABLE[0] && action_q[1:0] == 2'h1
    |=> !level_q[0])
    else $error("clear action did not clear channel 0");
  a_set_action: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    match_eq[1] && !PWM_CHANNEL_ENABLE[1] && action_q[3:2] == 2'h2
    |=> level_q[1])
    else $error("set action did not set channel 1");
  a_toggle_action: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    match_eq[2] && !PWM_CHANNEL_ENABLE[2] && action_q[5:4] == 2'h3
    |=> level_q[2] != $past(level_q[2]))
    else $error("toggle action did not toggle channel 2");
  a_none_action: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    match_eq[3] && !PWM_CHANNEL_ENABLE[3] && action_q[7:6] == 2'h0 &&
    !wr_fire |=> $stable(level_q[3]))
    else $error("idle action changed channel 3");
  a_ch0_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !match_eq[0] && !PWM_CHANNEL_ENABLE[0] && !wr_fire
    |=> $stable(level_q[0]))
    else $error("channel 0 moved without a match");
  a_pin_drive: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    ##1 MATCH_PIN_OE[0] |-> MATCH_PIN_OUT[0] == level_q[0])
    else $error("pin 0 does not follow its level");
  a_pwm_override: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    PWM_CHANNEL_ENABLE[1] |=> level_q[1] == $past(PWM_LEVEL[1]))
    else $error("pwm level not followed on channel 1");
  a_reset_state: assert property (
    @(posedge CORE_CLK)
    RST |=> level_q == 4'h0 && action_q == 8'h00)
    else $error("reset did not clear the register");
  a_write_load: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    wr_fire && wr_hit && wreq_q.strb[1]
    |=> action_q[7:4] == $past(wreq_q.data[11:8]))
    else $error("write did not load actions");
  a_read_level: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY && hit_reg(S_AXI_ARADDR)
    |=> S_AXI_RDATA[3:0] == $past(level_q))
    else $error("read did not return levels");
  a_read_action: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    S_AXI_ARVALID && S_AXI_ARREADY && hit_reg(S_AXI_ARADDR)
    |=> S_AXI_RDATA[11:4] == $past(action_q))
    else $error("read did not return actions");
  a_write_level: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    wr_fire && wr_hit && wreq_q.strb[0] && !match_eq[2] &&
    !PWM_CHANNEL_ENABLE[2] |=> level_q[2] == $past(wreq_q.data[2]))
    else $error("write did not load level 2");
  // every selected pin, not only pin 0, must show its level
  a_pin_all: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (MATCH_PIN_OUT & MATCH_PIN_OE) == (level_q & MATCH_PIN_OE))
    else $error("a selected pin does not follow its level");
  a_pin_idle: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    (MATCH_PIN_OUT & ~MATCH_PIN_OE) == 4'h0)
    else $error("an unselected pin is driven high");
  a_reset_pins: assert property (
    @(posedge CORE_CLK)
    RST |=> MATCH_PIN_OUT == 4'h0 && MATCH_PIN_OE == 4'h0)
    else $error("reset did not release the pins");

endmodule : temo_match_out

// File: test/temo_pin_model.sv
// behavioural board pins at the far side of the match outputs
`timescale 1ns/1ps
module temo_pin_model (
  input wire logic CORE_CLK,
  input wire logic [3:0] pin_drv,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_lvl
);
  logic [3:0] last_q = 4'h0;
  // remember the level last driven onto each pin
  always @(posedge CORE_CLK) begin
    last_q <= (pin_oe & pin_drv) | (~pin_oe & last_q);
  end
  // no pull resistor: a released pin shows the inverse, never the old level
  assign pin_lvl = (pin_oe & pin_drv) | (~pin_oe & ~last_q);
endmodule : temo_pin_model

// File: test/temo_match_out_tb.sv
// self-checking bench for the match output stage
`timescale 1ns/1ps
module temo_match_out_tb;
  import temo_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] cnt = 32'h0;
  logic [31:0] cmp = 32'h20;
  logic [3:0] pen = 4'h0;
  logic [3:0] plv = 4'h0;
  logic [3:0] psel = 4'h0;
  logic [3:0] pout, poe, pin, lv, ex;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [31:0] rdata, w, d;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, rs;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [31:0] A = MATCH_OUTPUT_CONTROL_ADDR;

  always #12.5 clk = ~clk;

  temo_match_out i_temo_match_out (.CORE_CLK(clk), .RST(rst),
    .TIMER_COUNT_VALUE(cnt), .COMPARE_VALUE_0(cmp), .COMPARE_VALUE_1(cmp),
    .COMPARE_VALUE_2(cmp), .COMPARE_VALUE_3(cmp), .MATCH_EVENT_EN(4'hf),
    .PWM_CHANNEL_ENABLE(pen), .PWM_LEVEL(plv), .PIN_FUNCTION_SELECT(psel),
    .MATCH_PIN_OUT(pout), .MATCH_PIN_OE(poe), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));

  temo_pin_model i_temo_pin_model (.CORE_CLK(clk), .pin_drv(pout),
    .pin_oe(poe), .pin_lvl(pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr));
    while (!bv) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v,
                        output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge clk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // counter equals every compare value for exactly one cycle
  task automatic pulse();
    @(posedge clk);
    cnt <= 32'h20;
    @(posedge clk);
    cnt <= 32'h0;
  endtask : pulse

  function automatic logic nx(input logic [1:0] a, input logic l);
    return (a == 2'h1) ? 1'b0 : (a == 2'h2) ? 1'b1 : (a == 2'h3) ? ~l : l;
  endfunction : nx

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // cut a hang short well after the sequence should have ended
  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pulse();
    rd_reg(A, d, rs);
    chk(d, 32'h0);
    psel <= 4'hf;
    // each pass rotates the four actions over the four channels
    for (int r = 0; r < 4; r++) begin
      lv = 4'(r * 3 + 5);
      w = {28'h0, lv};
      for (int k = 0; k < 4; k++) begin
        w[4 + 2 * k +: 2] = 2'(k + r);
        ex[k] = nx(2'(k + r), lv[k]);
      end
      // upper bits always written as zero
      wr_reg(A, w, rs);
      rd_reg(A, d, rs);
      chk(d, w);
      pulse();
      rd_reg(A, d, rs);
      chk(d, {w[31:4], ex});
      chk({28'h0, pin}, {28'h0, ex});
    end
    psel <= 4'h0;
    repeat (2) @(posedge clk);
    chk({24'h0, poe, pout}, 32'h0);
    // pwm channels ignore their clear action and follow the pwm level
    wr_reg(A, 32'h550, rs);
    pen <= 4'h3;
    plv <= 4'h3;
    pulse();
    rd_reg(A, d, rs);
    chk(d, 32'h553);
    pen <= 4'h0;
    // an unmapped word answers with an error and changes nothing
    wr_reg(A + 32'h4, 32'h0, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rd_reg(A + 32'h4, d, rs);
    chk({rs, d[29:0]}, {RESP_SLVERR, 30'h0});
    rd_reg(A, d, rs);
    chk({rs, d[29:0]}, {RESP_OKAY, 30'h553});
    give_verdict();
  end
endmodule : temo_match_out_tb
